// [pkg/dac_clear_pkg.sv]
// shared constants and types of the converter clear control block
`default_nettype none
package dac_clear_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CHAN = 12;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_SOURCE_SELECT = 8'h53;
  localparam logic [7:0] OFS_AUTO_CLEAR_EN = 8'h54;
  localparam logic [7:0] OFS_SOFT_CLEAR = 8'h55;
  localparam logic [7:0] OFS_PIN0_CLEAR_EN = 8'h56;
  localparam logic [7:0] OFS_ALARM_STATUS = 8'h70;
  localparam logic [7:0] OFS_ALARM_MASK = 8'h71;
  localparam logic [7:0] OFS_CLEAR_STATE = 8'h72;
  localparam logic [7:0] OFS_ALARM_CAUSE = 8'h73;
  localparam logic [7:0] OFS_PIN_CAUSE = 8'h74;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] RST_SOURCE_SELECT = 16'h0004;
  localparam logic [15:0] RST_AUTO_CLEAR_EN = 16'h0000;
  localparam logic [15:0] RST_SOFT_CLEAR = 16'h0000;
  localparam logic [15:0] RST_PIN0_CLEAR_EN = 16'h0000;
  localparam logic [15:0] RST_ALARM_MASK = 16'h0000;

  // ************************************************************
  // field positions and writable masks
  // ************************************************************
  localparam int CHAN_LSB = 3;
  localparam int CHAN_MSB = 14;
  localparam logic [15:0] CHAN_MASK = 16'h7ff8;
  localparam logic [15:0] SOURCE_MASK = 16'h7ffc;
  localparam int BIT_CH0_SRC = 14;
  localparam int BIT_CH1_SRC = 13;
  localparam int BIT_CH2_SRC = 12;
  localparam int BIT_CH3_SRC = 11;
  localparam int BIT_LT_LOW_SRC = 10;
  localparam int BIT_LT_HIGH_SRC = 9;
  localparam int BIT_R1_LOW_SRC = 8;
  localparam int BIT_R1_HIGH_SRC = 7;
  localparam int BIT_R2_LOW_SRC = 6;
  localparam int BIT_R2_HIGH_SRC = 5;
  localparam int BIT_R1_FAIL_SRC = 4;
  localparam int BIT_R2_FAIL_SRC = 3;
  localparam int BIT_OVERTEMP_SRC = 2;
  // alarms that obey the per-channel auto-clear enables
  localparam logic [15:0] GATED_ALARM_MASK = 16'h7ff8;

  // ************************************************************
  // carrier of one register port request
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage
`default_nettype wire

// [core/alarm_flag_bank.sv]
// sticky alarm status flags with write-one-to-clear
`default_nettype none
module alarm_flag_bank (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] set_i,
  input wire logic [15:0] clr_i,
  output logic [15:0] flags_o
);

  logic [15:0] flags_q;

  // set wins over clear so an alarm in the clearing cycle is kept
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= ((flags_q & ~clr_i) | set_i) & dac_clear_pkg::SOURCE_MASK;
    end
  end

  assign flags_o = flags_q;

endmodule
`default_nettype wire

// [core/dac_clear_control.sv]
// register bank and request combiner forcing converter channels into clear
//
// Our own choice: strobed register access.
`default_nettype none

// Function
// - channel-3 alarm clears enabled channels when its source select is set
// - unselected alarm still sets its flag but clears nothing
// - local temperature low/high source selects at bits 10 and 9, reset 0
// - first remote sensor low/high source selects at bits 8 and 7, reset 0
// - second remote sensor low/high source selects at bits 6 and 5, reset 0
// - remote sensor failure source selects at bits 4 and 3, reset 0
// - over-temperature source select at bit 2 resets to 1
// - source select bits 1 and 0 read zero, writes ignored
// - auto-clear enable per channel in bits 14 to 3, default 0
// - over-temperature alarm ignores enables and clears all channels when selected
// - software clear bit per channel; 1 clears, 0 restores
// - pin-0 enable per channel; low pin clears enabled channels only
// - analog channels 0 to 2 source selects at bits 14 to 12, reset 0
// - analog channel alarm flag set when input leaves its threshold window
// - every clear request acts on the next clock edge, whatever the load setting
module dac_clear_control (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire dac_clear_pkg::reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [15:0] alarm_event_i,
  input wire logic ext_clear_pin0_n_i,
  input wire logic [11:0] sync_load_en_i,
  output logic [11:0] dac_clear_o,
  output logic irq_o
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // pull the twelve channel bits out of a channel register image
  function automatic logic [11:0] chan_field(input logic [15:0] word);
    chan_field = word[dac_clear_pkg::CHAN_MSB:dac_clear_pkg::CHAN_LSB];
  endfunction

  // place twelve channel bits back at their register position
  function automatic logic [15:0] chan_word(input logic [11:0] chans);
    chan_word = {1'b0, chans, 3'b000};
  endfunction

  // decode a write strobe for one offset
  function automatic logic wr_hit(input dac_clear_pkg::reg_req_t req,
                                  input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  logic [15:0] source_sel_q;
  logic [15:0] auto_en_q;
  logic [15:0] soft_clear_q;
  logic [15:0] pin0_en_q;
  logic [15:0] alarm_mask_q;
  logic [15:0] alarm_flags;
  logic [15:0] flag_clr;
  logic [15:0] flag_set;
  logic [15:0] read_mux;
  logic [15:0] rdata_q;
  logic [11:0] auto_clear_chan_en;
  logic [11:0] soft_clear_chan;
  logic [11:0] pin0_clear_chan_en;
  logic [11:0] alarm_req;
  logic [11:0] soft_req;
  logic [11:0] pin_req;
  logic [11:0] clear_d;
  logic [11:0] clear_q;
  logic [11:0] alarm_req_q;
  logic [11:0] pin_req_q;
  logic gated_alarm_active;
  logic overtemp_active;
  logic irq_q;

  // ************************************************************
  // source select register
  // ************************************************************

  // each selectable alarm has a writable bit; reserved ones stay zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      source_sel_q <= dac_clear_pkg::RST_SOURCE_SELECT;
    end else if (wr_hit(reg_req_i, dac_clear_pkg::OFS_SOURCE_SELECT)) begin
      // bits 14..2 cover analog, temperature and failure alarms
      source_sel_q <= reg_req_i.wdata & dac_clear_pkg::SOURCE_MASK;
    end
  end

  // ************************************************************
  // per-channel enable and software clear registers
  // ************************************************************

  // auto-clear enable, reset all channels off
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      auto_en_q <= dac_clear_pkg::RST_AUTO_CLEAR_EN;
    end else if (wr_hit(reg_req_i, dac_clear_pkg::OFS_AUTO_CLEAR_EN)) begin
      auto_en_q <= reg_req_i.wdata & dac_clear_pkg::CHAN_MASK;
    end
  end

  // software clear, held until software writes a zero back
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      soft_clear_q <= dac_clear_pkg::RST_SOFT_CLEAR;
    end else if (wr_hit(reg_req_i, dac_clear_pkg::OFS_SOFT_CLEAR)) begin
      soft_clear_q <= reg_req_i.wdata & dac_clear_pkg::CHAN_MASK;
    end
  end

  // pin-0 enable, selects which channels follow the external pin
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin0_en_q <= dac_clear_pkg::RST_PIN0_CLEAR_EN;
    end else if (wr_hit(reg_req_i, dac_clear_pkg::OFS_PIN0_CLEAR_EN)) begin
      pin0_en_q <= reg_req_i.wdata & dac_clear_pkg::CHAN_MASK;
    end
  end

  // interrupt mask, same layout as the alarm status
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_mask_q <= dac_clear_pkg::RST_ALARM_MASK;
    end else if (wr_hit(reg_req_i, dac_clear_pkg::OFS_ALARM_MASK)) begin
      alarm_mask_q <= reg_req_i.wdata & dac_clear_pkg::SOURCE_MASK;
    end
  end

  assign auto_clear_chan_en = chan_field(auto_en_q);
  assign soft_clear_chan = chan_field(soft_clear_q);
  assign pin0_clear_chan_en = chan_field(pin0_en_q);

  // ************************************************************
  // alarm status flags
  // ************************************************************

  // flags latch whether or not the alarm is selected as a clear source;
  // the window compare lives upstream and arrives here as one event bit
  assign flag_set = alarm_event_i & dac_clear_pkg::SOURCE_MASK;

  // write one to clear; a concurrent event keeps its flag
  assign flag_clr = wr_hit(reg_req_i, dac_clear_pkg::OFS_ALARM_STATUS) ?
                    reg_req_i.wdata : 16'h0000;

  alarm_flag_bank u_flags (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .flags_o(alarm_flags)
  );

  // ************************************************************
  // clear request sources
  // ************************************************************

  // any flagged and selected alarm among those that honour the enables:
  // analog 0..3, local and remote temperature, remote failure
  assign gated_alarm_active = |(alarm_flags & source_sel_q &
                                dac_clear_pkg::GATED_ALARM_MASK);

  // over-temperature bypasses the per-channel enables entirely
  assign overtemp_active = alarm_flags[dac_clear_pkg::BIT_OVERTEMP_SRC] &
                           source_sel_q[dac_clear_pkg::BIT_OVERTEMP_SRC];

  // alarm request per channel
  always_comb begin
    alarm_req = auto_clear_chan_en & {dac_clear_pkg::NUM_CHAN{gated_alarm_active}};
    if (overtemp_active) begin
      alarm_req = {dac_clear_pkg::NUM_CHAN{1'b1}};
    end
  end

  // software request follows the register bits directly
  assign soft_req = soft_clear_chan;

  // pin is active low; disabled channels never see it
  assign pin_req = pin0_clear_chan_en &
                   {dac_clear_pkg::NUM_CHAN{~ext_clear_pin0_n_i}};

  // ************************************************************
  // channel clear combiner
  // ************************************************************

  // sync load enables only govern data loading, so they take no part here;
  // a channel leaves clear only once every source has gone away
  assign clear_d = alarm_req | soft_req | pin_req;

  // one register stage keeps the output glitch free at a cost of one cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clear_q <= 12'h000;
    end else begin
      clear_q <= clear_d;
    end
  end

  // cause snapshots for software diagnosis
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_req_q <= 12'h000;
      pin_req_q <= 12'h000;
    end else begin
      alarm_req_q <= alarm_req;
      pin_req_q <= pin_req;
    end
  end

  assign dac_clear_o = clear_q;

  // ************************************************************
  // interrupt
  // ************************************************************

  // level output, high while any flag whose mask bit is one is set
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(alarm_flags & alarm_mask_q);
    end
  end

  assign irq_o = irq_q;

  // ************************************************************
  // read path
  // ************************************************************

  // reserved bits are already zero in storage, unmapped reads give zero
  always_comb begin
    case (reg_req_i.addr)
      dac_clear_pkg::OFS_SOURCE_SELECT: begin
        read_mux = source_sel_q;
      end
      dac_clear_pkg::OFS_AUTO_CLEAR_EN: begin
        read_mux = auto_en_q;
      end
      dac_clear_pkg::OFS_SOFT_CLEAR: begin
        read_mux = soft_clear_q;
      end
      dac_clear_pkg::OFS_PIN0_CLEAR_EN: begin
        read_mux = pin0_en_q;
      end
      dac_clear_pkg::OFS_ALARM_STATUS: begin
        read_mux = alarm_flags;
      end
      dac_clear_pkg::OFS_ALARM_MASK: begin
        read_mux = alarm_mask_q;
      end
      dac_clear_pkg::OFS_CLEAR_STATE: begin
        read_mux = chan_word(clear_q);
      end
      dac_clear_pkg::OFS_ALARM_CAUSE: begin
        read_mux = chan_word(alarm_req_q);
      end
      dac_clear_pkg::OFS_PIN_CAUSE: begin
        read_mux = chan_word(pin_req_q);
      end
      default: begin
        read_mux = 16'h0000;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_req_i.rd) begin
      rdata_q <= read_mux;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule
`default_nettype wire

// [verification/dac_clear_sva.sv]
// shadow-model checker for the converter clear control block
`default_nettype none
module dac_clear_sva (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire dac_clear_pkg::reg_req_t reg_req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [15:0] alarm_event_i,
  input wire logic ext_clear_pin0_n_i,
  input wire logic [11:0] dac_clear_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sel_q, aen_q, sw_q, pen_q, fl_q, mk_q;
  logic [11:0] clr_d, clr_q, aen_c, sw_c, pen_c;
  logic irq_q, rd, wr, gate;
  logic [7:0] a;
  logic [15:0] d;
  assign {rd, wr, a, d} = {reg_req_i.rd, reg_req_i.wr, reg_req_i.addr, reg_req_i.wdata};
  assign {aen_c, sw_c, pen_c} = {aen_q[14:3], sw_q[14:3], pen_q[14:3]};
  assign gate = |(fl_q & sel_q & dac_clear_pkg::GATED_ALARM_MASK);
  // expected clear: any cause, no load setting involved
  assign clr_d = (gate ? aen_c : 12'h0) | ((fl_q[2] & sel_q[2]) ? 12'hfff : 12'h0)
    | sw_c | (ext_clear_pin0_n_i ? 12'h0 : pen_c);
  // shadow registers track writes seen at the port; set beats clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= 16'h0004;
      {aen_q, sw_q, pen_q, fl_q, mk_q} <= '0;
      {clr_q, irq_q} <= '0;
    end else begin
      if (wr && a == 8'h53) sel_q <= d & 16'h7ffc;
      if (wr && a == 8'h54) aen_q <= d & 16'h7ff8;
      if (wr && a == 8'h55) sw_q <= d & 16'h7ff8;
      if (wr && a == 8'h56) pen_q <= d & 16'h7ff8;
      if (wr && a == 8'h71) mk_q <= d & 16'h7ffc;
      fl_q <= (fl_q & ~((wr && a == 8'h70) ? d : 16'h0)) | (alarm_event_i & 16'h7ffc);
      clr_q <= clr_d;
      irq_q <= |(fl_q & mk_q);
    end
  end
  // ************
  // properties
  // ************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_CLEAR_MODEL: assert property (dac_clear_o == clr_q)
    else $error("clear output differs from model");
  AST_SOFT: assert property ((sw_c != 12'h0) |=> ((dac_clear_o & $past(sw_c)) == $past(sw_c)))
    else $error("software clear not applied");
  AST_PIN: assert property (!ext_clear_pin0_n_i |=> ((dac_clear_o & $past(pen_c)) == $past(pen_c)))
    else $error("pin clear not applied");
  AST_GATED: assert property (gate |=> ((dac_clear_o & $past(aen_c)) == $past(aen_c)))
    else $error("alarm clear not applied");
  AST_OVERTEMP: assert property ((fl_q[2] && sel_q[2]) |=> (dac_clear_o == 12'hfff))
    else $error("thermal alarm did not clear all");
  AST_IRQ: assert property (irq_o == irq_q)
    else $error("interrupt level wrong");
  AST_RD_IDLE: assert property (!rd |=> (reg_rdata_o == 16'h0))
    else $error("read data outside read slot");
  AST_SRC_READ: assert property ((rd && a == 8'h53) |=> (reg_rdata_o == $past(sel_q)))
    else $error("source select readback wrong");
  AST_CHAN_READ: assert property ((rd && a inside {[8'h54:8'h56]}) |=> ((reg_rdata_o & 16'h8007) == 16'h0))
    else $error("unused channel bits not zero");
  AST_UNMAPPED: assert property ((rd && !(a inside {[8'h53:8'h56], [8'h70:8'h74]})) |=> (reg_rdata_o == 16'h0))
    else $error("unmapped read not zero");
  COV_OVERTEMP: cover property (fl_q[2] && sel_q[2] && dac_clear_o == 12'hfff);
  COV_PIN: cover property (!ext_clear_pin0_n_i && pen_c != 12'h0);
  COV_IRQ: cover property (irq_o);
endmodule
bind dac_clear_control dac_clear_sva u_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .alarm_event_i(alarm_event_i),
  .ext_clear_pin0_n_i(ext_clear_pin0_n_i), .dac_clear_o(dac_clear_o), .irq_o(irq_o));
`default_nettype wire

// [verification/clear_pin_model.sv]
// outside party driving the active-low clear pin
`default_nettype none
module clear_pin_model (
  input wire logic ref_clk_i,
  input wire logic assert_i,
  output logic pin_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_q = 1'b1;
  // idles high as a pulled-up line; moves only after an edge
  always @(posedge ref_clk_i) pin_q <= ~assert_i;
  // single driver for the pin, start value held by the register
  assign pin_n_o = pin_q;
endmodule
`default_nettype wire

// [verification/tb_dac_clear_control.sv]
// self-checking bench of the converter clear control block
`default_nettype none
module tb_dac_clear_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  dac_clear_pkg::reg_req_t req = '0;
  logic [15:0] rdata;
  logic [15:0] evt = 16'h0;
  logic [11:0] sld = 12'h0;
  logic [11:0] clr;
  logic pin_req = 1'b0;
  logic pin_n, irq;
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'd42140;
  logic [15:0] expq[$];
  int bad_count = 0;
  int num_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  dac_clear_control DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .alarm_event_i(evt), .ext_clear_pin0_n_i(pin_n),
    .sync_load_en_i(sld), .dac_clear_o(clr), .irq_o(irq));
  clear_pin_model host (.ref_clk_i(ref_clk_i), .assert_i(pin_req), .pin_n_o(pin_n));
  // ************
  // helpers
  // ************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic note(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    expq.push_back(e);
    @(posedge ref_clk_i);
    req.rd <= 1'b0;
  endtask
  task automatic fire(input int b);
    @(posedge ref_clk_i);
    evt <= 16'h1 << b;
    @(posedge ref_clk_i);
    evt <= 16'h0;
  endtask
  // levels are steady by then, so a few spare edges cost nothing
  task automatic chk(input logic [11:0] e, input logic ei);
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    note("dac_clear", {4'h0, e}, {4'h0, clr});
    note("irq", {15'h0, ei}, {15'h0, irq});
  endtask
  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // read data stand one cycle only, so compare mid-cycle
  always @(posedge ref_clk_i) rd_d <= req.rd;
  always @(negedge ref_clk_i) if (rd_d) note("reg_rdata", expq.pop_front(), rdata);
  // load enables wander at random; clears must not care
  always @(posedge ref_clk_i) sld <= seed[27:16];
  initial begin
    #3000000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(8'h53, 16'h0004);
    for (int i = 4; i <= 6; i++) rd(8'h50 + i[7:0], 16'h0);
    rd(8'h20, 16'h0);
    for (int i = 3; i <= 6; i++) begin
      wr(8'h50 + i[7:0], 16'hffff);
      rd(8'h50 + i[7:0], (i == 3) ? 16'h7ffc : 16'h7ff8);
    end
    wr(8'h56, 16'h0);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      wr(8'h55, seed[15:0]);
      rd(8'h55, seed[15:0] & 16'h7ff8);
      chk(seed[14:3], 1'b0);
    end
    wr(8'h55, 16'h0);
    // each gated alarm: first unselected, then selected
    for (int b = 3; b <= 14; b++) begin
      seed = xs(seed);
      wr(8'h54, seed[15:0]);
      wr(8'h53, 16'h0);
      fire(b);
      chk(12'h0, 1'b0);
      rd(8'h70, 16'h1 << b);
      wr(8'h53, 16'h1 << b);
      chk(seed[14:3], 1'b0);
      wr(8'h70, 16'hffff);
      chk(12'h0, 1'b0);
    end
    wr(8'h54, 16'h0);
    fire(2);
    chk(12'h0, 1'b0);
    wr(8'h53, 16'h0004);
    chk(12'hfff, 1'b0);
    rd(8'h72, 16'h7ff8);
    rd(8'h73, 16'h7ff8);
    wr(8'h70, 16'h0004);
    seed = xs(seed);
    wr(8'h56, seed[15:0]);
    pin_req <= 1'b1;
    chk(seed[14:3], 1'b0);
    rd(8'h74, seed[15:0] & 16'h7ff8);
    pin_req <= 1'b0;
    chk(12'h0, 1'b0);
    wr(8'h71, 16'h0020);
    fire(5);
    chk(12'h0, 1'b1);
    rd(8'h71, 16'h0020);
    wr(8'h71, 16'h0);
    chk(12'h0, 1'b0);
    wr(8'h71, 16'h0020);
    // event and clear in one cycle: the flag must survive
    fork
      fire(5);
      wr(8'h70, 16'h0020);
    join
    rd(8'h70, 16'h0020);
    chk(12'h0, 1'b1);
    wr(8'h70, 16'h0020);
    chk(12'h0, 1'b0);
    // second reset mid-run: source select, software clear and mask read back their defaults
    wr(8'h55, 16'h7ff8);
    rstn_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(8'h53, 16'h0004);
    rd(8'h55, 16'h0000);
    rd(8'h71, 16'h0000);
    chk(12'h0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
